//--- rtl/imq_top.sv
/*
 * imq_top: interpolating datapath with coarse mixer, quadrature correction
 * and offset, configured over APB.
 * assumes the sample source shares the conversion clock and presents the
 * next word combinationally while fifoRead is high.
 */
`timescale 1ns/1ps
module imq_top (
    input  wire logic               clock,
    input  wire logic               resetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    fifoRead,
    input  wire imq_pkg::imq_pair_s fifoData,
    output imq_pkg::imq_pair_s      dacOut
);
    import imq_pkg::*;

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  cnt;
        logic [1:0]  mixPh;
        logic [1:0]  interp;
        logic [1:0]  mix;
        imq_corr_s   stageCorr;
        imq_corr_s   actCorr;
        imq_off_s    stageOff;
        imq_off_s    actOff;
        imq_pair_s   mixOut;
        logic [31:0] rdata;
        logic        slvErr;
    } imq_state_s;

    imq_state_s        q;
    imq_state_s        d;
    imq_interp_e       mode;
    imq_mix_e          mixSel;
    logic [1:0]        lastCnt;
    logic [1:0]        rotPh;
    logic              apbSetup;
    logic              apbWrite;
    logic [1:0][15:0]  stage0;
    logic [1:0][15:0]  stage1In;
    logic [1:0][15:0]  even0;
    logic [1:0][15:0]  odd0;
    logic [1:0][15:0]  even1;
    logic [1:0][15:0]  odd1;
    logic [1:0][15:0]  strm;
    imq_pair_s         stream;
    logic              hb1En;

    // -----------------------------------------------------------------
    // register decode
    // -----------------------------------------------------------------
    function automatic logic isMapped(input logic [7:0] a);
        case (a)
            A_CTRL, A_GAINA, A_GAINB, A_CORRLD, A_OFFB,
            A_OFFLD, A_ACTCORR, A_ACTOFF, A_STATUS: return 1'b1;
            default:                                return 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] regRead(input logic [7:0] a,
                                            input imq_state_s s);
        logic [31:0] r;
        r = '0;
        case (a)
            A_CTRL: begin
                r[CTRL_INTERP_LSB +: 2] = s.interp;
                r[CTRL_MIX_LSB +: 2]    = s.mix;
            end
            A_GAINA:   r[10:0] = s.stageCorr.gainA;
            A_GAINB:   r[10:0] = s.stageCorr.gainB;
            A_CORRLD:  r[9:0]  = s.stageCorr.phase;
            A_OFFB:    r[12:0] = s.stageOff.offB;
            A_OFFLD:   r[12:0] = s.stageOff.offA;
            A_ACTCORR: r       = s.actCorr;
            A_ACTOFF:  r[25:0] = s.actOff;
            A_STATUS: begin
                r[STAT_CNT_LSB +: 2] = s.cnt;
                r[STAT_PH_LSB +: 2]  = s.mixPh;
            end
            default:   r = '0;
        endcase
        return r;
    endfunction

    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite;
    assign mode     = imq_interp_e'(q.interp);
    assign mixSel   = imq_mix_e'(q.mix);

    // -----------------------------------------------------------------
    // interpolation filters
    // -----------------------------------------------------------------
    assign fifoRead = (q.cnt == 2'h0);
    assign stage0   = fifoData;
    assign hb1En    = q.cnt[0];

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        assign stage1In[ch] = q.cnt[1] ? odd0[ch] : even0[ch];

        imq_halfband #(
            .N     (HB0_N),
            .COEF  (HB0_COEF),
            .SHIFT (HB0_SHIFT)
        ) u_first_halfband_filter (
            .clock    (clock),
            .resetn   (resetn),
            .inEn     (fifoRead),
            .sampleIn (stage0[ch]),
            .evenOut  (even0[ch]),
            .oddOut   (odd0[ch])
        );

        imq_halfband #(
            .N     (HB1_N),
            .COEF  (HB1_COEF),
            .SHIFT (HB1_SHIFT)
        ) u_second_halfband_filter (
            .clock    (clock),
            .resetn   (resetn),
            .inEn     (hb1En),
            .sampleIn (stage1In[ch]),
            .evenOut  (even1[ch]),
            .oddOut   (odd1[ch])
        );
    end

    // -----------------------------------------------------------------
    // rate select, mixer and register writes
    // -----------------------------------------------------------------
    always_comb begin
        d     = q;
        rotPh = q.mixPh;

        unique case (mode)
            IMQ_2X: begin
                lastCnt = 2'h1;
                strm    = q.cnt[0] ? even0 : odd0;
            end
            IMQ_4X: begin
                lastCnt = 2'h3;
                strm    = q.cnt[0] ? odd1 : even1;
            end
            default: begin
                lastCnt = 2'h0;
                strm    = fifoData;
            end
        endcase
        stream = imq_pair_s'(strm);

        d.cnt = (q.cnt >= lastCnt) ? 2'h0 : q.cnt + 2'h1;

        // coarse mixer, one step per output sample
        if (mode == IMQ_2X || mode == IMQ_4X) begin
            d.mixPh = q.mixPh + 2'h1;
            if (mixSel == MIX_NEG_QTR) begin
                rotPh = 2'h0 - q.mixPh;
            end
            unique case (mixSel)
                MIX_NONE: d.mixOut = stream;
                MIX_HALF: begin
                    d.mixOut = stream;
                    if (q.mixPh[0]) begin
                        d.mixOut.a = imq_neg(stream.a);
                        d.mixOut.b = imq_neg(stream.b);
                    end
                end
                MIX_POS_QTR, MIX_NEG_QTR: begin
                    unique case (rotPh)
                        2'h0: begin
                            d.mixOut.a = stream.a;
                            d.mixOut.b = stream.b;
                        end
                        2'h1: begin
                            d.mixOut.a = imq_neg(stream.b);
                            d.mixOut.b = stream.a;
                        end
                        2'h2: begin
                            d.mixOut.a = imq_neg(stream.a);
                            d.mixOut.b = imq_neg(stream.b);
                        end
                        2'h3: begin
                            d.mixOut.a = stream.b;
                            d.mixOut.b = imq_neg(stream.a);
                        end
                    endcase
                end
            endcase
        end else begin
            d.mixPh  = 2'h0;
            d.mixOut = stream;
        end

        // apb: answer prepared in setup, write lands in access
        if (apbSetup) begin
            d.rdata  = pwrite ? 32'h0 : regRead(paddr, q);
            d.slvErr = !isMapped(paddr);
        end
        if (apbWrite) begin
            case (paddr)
                A_CTRL: begin
                    d.interp = pwdata[CTRL_INTERP_LSB +: 2];
                    d.mix    = pwdata[CTRL_MIX_LSB +: 2];
                    d.cnt    = 2'h0;
                    d.mixPh  = 2'h0;
                end
                A_GAINA: d.stageCorr.gainA = pwdata[10:0];
                A_GAINB: d.stageCorr.gainB = pwdata[10:0];
                A_CORRLD: begin
                    d.stageCorr.phase = pwdata[9:0];
                    d.actCorr         = {q.stageCorr.gainA,
                                         q.stageCorr.gainB, pwdata[9:0]};
                end
                A_OFFB:  d.stageOff.offB = pwdata[12:0];
                A_OFFLD: begin
                    d.stageOff.offA = pwdata[12:0];
                    d.actOff        = {pwdata[12:0], q.stageOff.offB};
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            q                 <= '0;
            q.stageCorr.gainA <= GAIN_RST;
            q.stageCorr.gainB <= GAIN_RST;
            q.stageCorr.phase <= PHASE_RST;
            q.actCorr.gainA   <= GAIN_RST;
            q.actCorr.gainB   <= GAIN_RST;
            q.actCorr.phase   <= PHASE_RST;
            q.stageOff        <= {OFF_RST, OFF_RST};
            q.actOff          <= {OFF_RST, OFF_RST};
        end else begin
            q <= d;
        end
    end

    // -----------------------------------------------------------------
    // correction and offset
    // -----------------------------------------------------------------
    imq_correct u_correct (
        .clock     (clock),
        .resetn    (resetn),
        .sampleIn  (q.mixOut),
        .corr      (q.actCorr),
        .off       (q.actOff),
        .sampleOut (dacOut)
    );

    assign pready  = 1'b1;
    assign prdata  = q.rdata;
    assign pslverr = psel && penable && q.slvErr;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    read_rate4_a: assert property (
        disable iff (!resetn || (psel && pwrite && paddr == A_CTRL))
        (fifoRead && mode == IMQ_4X && !apbWrite)
        |=> !fifoRead ##1 !fifoRead ##1 !fifoRead)
        else $error("sample read faster than quarter rate");

    read_rate2_a: assert property (
        (fifoRead && mode == IMQ_2X && !apbWrite) |=> !fifoRead ##1 fifoRead)
        else $error("sample read not at half rate");

    corr_hold_a: assert property (
        !(apbWrite && paddr == A_CORRLD) |=> $stable(q.actCorr))
        else $error("active correction changed without load");

    corr_load_a: assert property (
        (apbWrite && paddr == A_CORRLD)
        |=> q.actCorr == {$past(q.stageCorr.gainA), $past(q.stageCorr.gainB),
                          $past(pwdata[9:0])})
        else $error("correction load did not take staged values");

    off_hold_a: assert property (
        !(apbWrite && paddr == A_OFFLD) |=> $stable(q.actOff))
        else $error("active offset changed without load");

    off_load_a: assert property (
        (apbWrite && paddr == A_OFFLD)
        |=> q.actOff == {$past(pwdata[12:0]), $past(q.stageOff.offB)})
        else $error("offset load did not take both values");

    mix_bypass_a: assert property (
        (mode == IMQ_1X) |=> q.mixOut == $past(fifoData))
        else $error("non-interpolating path was altered");

    mix_half_a: assert property (
        (mode == IMQ_2X && mixSel == MIX_HALF && q.mixPh[0])
        |=> q.mixOut.a == imq_neg($past(stream.a))
            && q.mixOut.b == imq_neg($past(stream.b)))
        else $error("half-rate mixer did not negate");

    mix_quarter_a: assert property (
        (mode == IMQ_4X && mixSel == MIX_POS_QTR && q.mixPh == 2'h1)
        |=> q.mixOut.a == imq_neg($past(stream.b))
            && q.mixOut.b == $past(stream.a))
        else $error("quarter mixer step one wrong");

    load_corr_c: cover property (apbWrite && paddr == A_CORRLD);
    load_off_c:  cover property (apbWrite && paddr == A_OFFLD);
    mix4_c:      cover property (mode == IMQ_4X && mixSel == MIX_NEG_QTR
                                 && q.mixPh == 2'h3);
    half2_c:     cover property (mode == IMQ_2X && mixSel == MIX_HALF);

endmodule // imq_top

//--- rtl/imq_pkg.sv
/*
 * imq_pkg: constants, types and helpers for the interpolating mixer with
 * quadrature correction and offset stage.
 * assumes one conversion clock and an APB register port, both in one domain.
 */
// Functional notes
// - first half-band filter: symmetric 59 taps, zero alternate taps, centre 32768, doubles rate
// - second half-band filter: symmetric 23 taps, listed coefficients, centre 4096
// - 2x uses the first filter only; 4x cascades first then second filter
// - mixer lives inside the interpolator; never active without interpolation
// - mixer 00 passes both channels; 01 negates both on every other sample
// - mixer 10 and 11 rotate A and B by quarter turns, period four
// - half-rate mixing keeps channels independent, spectrum lands inverted at the top
// - filters give 0.4 to 0.6 transition, small ripple, deep stop band
// - I and Q scaled by separate unsigned 11-bit gains, 0 to nearly 2
// - signed 10-bit phase times Q is added into I, range plus minus 1/8
// - gains and phase go active together only on correction load write
// - each channel has its own 13-bit signed offset, -4096 to 4095
// - offset added straight onto the data, both LSB aligned
// - both offsets go active together only on offset load write
// - input word carries 16-bit A (I) and 16-bit B (Q) together
// - samples taken at conversion clock divided by interpolation factor
package imq_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam int         ADDR_W    = 8;
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_GAINA   = 8'h04;
    localparam logic [7:0] A_GAINB   = 8'h08;
    localparam logic [7:0] A_CORRLD  = 8'h0c;
    localparam logic [7:0] A_OFFB    = 8'h10;
    localparam logic [7:0] A_OFFLD   = 8'h14;
    localparam logic [7:0] A_ACTCORR = 8'h18;
    localparam logic [7:0] A_ACTOFF  = 8'h1c;
    localparam logic [7:0] A_STATUS  = 8'h20;

    localparam int CTRL_INTERP_LSB = 0;
    localparam int CTRL_MIX_LSB    = 2;
    localparam int STAT_CNT_LSB    = 0;
    localparam int STAT_PH_LSB     = 2;

    localparam logic [10:0] GAIN_RST  = 11'h400;
    localparam logic [9:0]  PHASE_RST = 10'h000;
    localparam logic [12:0] OFF_RST   = 13'h0000;
    localparam int          GAIN_FRAC  = 10;
    localparam int          PHASE_FRAC = 12;

    // -----------------------------------------------------------------
    // filter coefficients, outer tap first
    // -----------------------------------------------------------------
    localparam int HB0_N     = 15;
    localparam int HB0_SHIFT = 15;
    localparam logic [0:HB0_N-1][15:0] HB0_COEF = '{
        16'sd4, -16'sd12, 16'sd28, -16'sd58, 16'sd108, -16'sd188, 16'sd308,
        -16'sd483, 16'sd734, -16'sd1091, 16'sd1607, -16'sd2392, 16'sd3732,
        -16'sd6681, 16'sd20768};
    localparam int HB1_N     = 6;
    localparam int HB1_SHIFT = 12;
    localparam logic [0:HB1_N-1][15:0] HB1_COEF = '{
        -16'sd2, 16'sd17, -16'sd75, 16'sd238, -16'sd660, 16'sd2530};

    localparam logic signed [39:0] SAT_MAX = 40'sh0000007fff;
    localparam logic signed [39:0] SAT_MIN = 40'shffffff8000;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {IMQ_1X, IMQ_2X, IMQ_4X, IMQ_RSV} imq_interp_e;
    typedef enum logic [1:0] {MIX_NONE, MIX_HALF, MIX_POS_QTR, MIX_NEG_QTR} imq_mix_e;

    typedef struct packed {
        logic signed [15:0] b;
        logic signed [15:0] a;
    } imq_pair_s;

    typedef struct packed {
        logic        [10:0] gainA;
        logic        [10:0] gainB;
        logic signed [9:0]  phase;
    } imq_corr_s;

    typedef struct packed {
        logic signed [12:0] offA;
        logic signed [12:0] offB;
    } imq_off_s;

    function automatic logic signed [15:0] imq_sat16(input logic signed [39:0] v);
        if (v > SAT_MAX) return 16'sh7fff;
        if (v < SAT_MIN) return 16'sh8000;
        return v[15:0];
    endfunction

    function automatic logic signed [15:0] imq_neg(input logic signed [15:0] v);
        return imq_sat16(40'sh0 - 40'(v));
    endfunction

endpackage

//--- rtl/imq_halfband.sv
/*
 * imq_halfband: one channel of a 2x half-band interpolator in polyphase form.
 * assumes inEn pulses once per input sample; both output phases are held
 * until the next inEn and the caller picks even then odd.
 */
`timescale 1ns/1ps
module imq_halfband #(
    parameter int                 N     = 15,
    parameter logic [0:N-1][15:0] COEF  = '0,
    parameter int                 SHIFT = 15
)(
    input  wire logic               clock,
    input  wire logic               resetn,
    input  wire logic               inEn,
    input  wire logic signed [15:0] sampleIn,
    output logic signed [15:0]      evenOut,
    output logic signed [15:0]      oddOut
);
    import imq_pkg::*;

    typedef struct packed {
        logic [2*N-1:0][15:0] win;
        logic signed [15:0]   even;
        logic signed [15:0]   odd;
    } imq_hb_s;

    imq_hb_s            q;
    imq_hb_s            d;
    logic signed [39:0] acc;
    logic signed [16:0] pairSum;

    if (N < 2 || SHIFT < 1 || SHIFT > 24) begin : g_check
        $error("imq_halfband: unsupported N or SHIFT");
    end

    // -----------------------------------------------------------------
    // symmetric pre-add, one product per coefficient pair
    // -----------------------------------------------------------------
    always_comb begin
        d       = q;
        acc     = '0;
        pairSum = '0;
        if (inEn) begin
            d.win = {q.win[2*N-2:0], sampleIn};
            for (int j = 0; j < N; j++) begin
                pairSum = 17'($signed(d.win[j])) + 17'($signed(d.win[2*N-1-j]));
                acc     = acc + 40'(pairSum) * 40'($signed(COEF[j]));
            end
            d.even = imq_sat16(acc >>> SHIFT);
            d.odd  = $signed(d.win[N-1]);         // centre tap is unity gain
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign evenOut = q.even;
    assign oddOut  = q.odd;

endmodule // imq_halfband

//--- rtl/imq_correct.sv
/*
 * imq_correct: gain and phase correction followed by the offset adder.
 * assumes settings come from the load-gated active copies in the top.
 */
`timescale 1ns/1ps
module imq_correct (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire imq_pkg::imq_pair_s sampleIn,
    input  wire imq_pkg::imq_corr_s corr,
    input  wire imq_pkg::imq_off_s  off,
    output imq_pkg::imq_pair_s      sampleOut
);
    import imq_pkg::*;

    imq_pair_s          q;
    imq_pair_s          d;
    logic signed [39:0] iMix;
    logic signed [39:0] iGain;
    logic signed [39:0] qGain;

    always_comb begin
        iMix  = (40'(sampleIn.a) <<< PHASE_FRAC)
              + 40'(sampleIn.b) * 40'(corr.phase);
        iGain = (iMix * 40'($signed({1'b0, corr.gainA})))
              >>> (PHASE_FRAC + GAIN_FRAC);
        qGain = (40'(sampleIn.b) * 40'($signed({1'b0, corr.gainB}))) >>> GAIN_FRAC;
        d.a   = imq_sat16(40'(imq_sat16(iGain)) + 40'(off.offA));
        d.b   = imq_sat16(40'(imq_sat16(qGain)) + 40'(off.offB));
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sampleOut = q;

endmodule // imq_correct

//--- sim/imq_fifo_model.sv
/*
 * imq_fifo_model: sample source on the far side of the datapath.
 * assumes the bench hands the next paired word in on nextWord.
 */
`timescale 1ns/1ps
module imq_fifo_model (
    input  wire logic          fifoRead,
    input  wire logic [31:0]   nextWord,
    output imq_pkg::imq_pair_s fifoData
);
    import imq_pkg::*;
    // --------------------------------------------------------------
    // word offered only while read, else inverted so a stray take shows
    // --------------------------------------------------------------
    assign fifoData = fifoRead ? imq_pair_s'(nextWord) : imq_pair_s'(~nextWord);
endmodule // imq_fifo_model

//--- sim/imq_top_bench.sv
/*
 * imq_top_bench: self-checking bench for the interpolating mixer datapath.
 * assumes imq_pkg, imq_top and imq_fifo_model are compiled first.
 */
`timescale 1ns/1ps
module imq_top_bench;
    import imq_pkg::*;
    logic        clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        fifoRead, pready, pslverr, err, chk = 0, run = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, nextWord = '0, o [8];
    logic [31:0] rnd = 32'h75d0e569, seed = 32'h75d0e569;
    imq_pair_s   fifoData, dacOut, h0, h1;
    int          miscompares = 0, samples_checked = 0, cyc = 0;
    int          ga = 1024, gb = 1024, ph = 0, oa = 0, ob = 0, k, nrd, mx, wt;

    imq_top i_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fifoRead(fifoRead), .fifoData(fifoData), .dacOut(dacOut));
    imq_fifo_model i_src (.fifoRead(fifoRead), .nextWord(nextWord), .fifoData(fifoData));

    initial forever #2 clock = ~clock;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    function automatic longint sat(longint v);
        return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
    endfunction

    function automatic logic [31:0] model(imq_pair_s s);
        longint i = sat((longint'(s.a) * 4096 + longint'(s.b) * ph) * ga >>> 22) + oa;
        longint q = sat(longint'(s.b) * gb >>> 10) + ob;
        return {16'(sat(q)), 16'(sat(i))};
    endfunction

    function automatic logic [31:0] mix(int m, int n);
        int a = 1000, b = -3000, x, y;
        case (m * 4 + n)
            5, 7, 10, 14: begin x = -a; y = -b; end
            9, 15: begin x = -b; y = a; end
            11, 13: begin x = b; y = -a; end
            default: begin x = a; y = b; end
        endcase
        return {16'(y), 16'(x)};
    endfunction

    task automatic check(string name, logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n = 0;
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        wt = n;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic rdchk(logic [7:0] a, logic [31:0] exp, string name);
        apb(0, a, 0);
        check(name, rd, exp);
        check("readErr", 32'(err), 32'h0);
        check("accessCycles", 32'(wt), 32'h1);
    endtask

    task automatic final_report();
        $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // stream capture, random source, result compare, timeout
    // --------------------------------------------------------------
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (fifoRead) h0 <= fifoData;
        h1 <= h0;
        if (run) begin
            rnd = xs(rnd);
            nextWord <= rnd;
        end
        if (cyc > 10000) begin
            miscompares++;
            final_report();
        end
    end

    always @(negedge clock)
        if (chk) check("dacOut", dacOut, model(h1));

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1;
        nextWord <= {16'hf448, 16'h03e8};
        for (int f = 0; f < 4; f++)
            for (int m = 0; m < 4; m++) begin
                apb(1, A_CTRL, 32'(m * 4 + f));
                repeat (200) @(posedge clock);
                nrd = 0;
                mx = (f % 3) ? m : 0;
                for (int i = 0; i < 8; i++) begin
                    @(negedge clock);
                    o[i] = dacOut;
                    nrd += int'(fifoRead);
                end
                k = 0;
                while (k < 3 && o[0] !== mix(mx, k)) k++;
                for (int i = 0; i < 8; i++)
                    check("mix", o[i], mix(mx, (k + i) & 3));
                check("readRate", 32'(nrd), 32'(8 >> (f % 3)));
            end
        apb(1, A_CTRL, 0);
        run = 1;
        rdchk(A_STATUS, 32'h0, "status1x");
        rdchk(A_ACTCORR, 32'h80100000, "corrReset");
        apb(0, 8'h24, 0);
        check("unmappedErr", 32'(err), 1);
        for (int r = 0; r < 3; r++) begin
            chk = 0;
            seed = xs(seed);
            apb(1, A_GAINA, 32'(seed[10:0]));
            apb(1, A_GAINB, 32'(seed[21:11]));
            rdchk(A_GAINA, 32'(seed[10:0]), "gainStaged");
            rdchk(A_ACTCORR, {ga[10:0], gb[10:0], ph[9:0]}, "corrStaged");
            apb(1, A_CORRLD, 32'(seed[31:22]));
            ga = int'(seed[10:0]);
            gb = int'(seed[21:11]);
            ph = int'($signed(seed[31:22]));
            rdchk(A_ACTCORR, {ga[10:0], gb[10:0], ph[9:0]}, "corrActive");
            seed = xs(seed);
            apb(1, A_OFFB, 32'(seed[12:0]));
            rdchk(A_ACTOFF, {6'h0, 13'(oa), 13'(ob)}, "offStaged");
            apb(1, A_OFFLD, 32'(seed[28:16]));
            oa = int'($signed(seed[28:16]));
            ob = int'($signed(seed[12:0]));
            rdchk(A_ACTOFF, {6'h0, 13'(oa), 13'(ob)}, "offActive");
            repeat (3) @(posedge clock);
            chk = 1;
            repeat (300) @(posedge clock);
        end
        final_report();
    end
endmodule // imq_top_bench
